/* inc/timer_pkg.sv */
// constants and carrier types of the counter/timer pair
// assumes byte-wide registers reached over a plain strobe port
package timer_pkg;
    // register offsets on the strobe port
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_A_LOW = 4'h0;
    localparam logic [3:0] OFS_A_HIGH = 4'h1;
    localparam logic [3:0] OFS_B_LOW = 4'h2;
    localparam logic [3:0] OFS_B_HIGH = 4'h3;
    localparam logic [3:0] OFS_RUN_STATUS = 4'h4;
    localparam logic [3:0] OFS_MODE = 4'h5;
    localparam logic [3:0] OFS_CLK_CTRL = 4'h6;
    localparam logic [3:0] OFS_IRQ_EN = 4'h7;
    localparam logic [3:0] OFS_EXT_CFG = 4'h8;
    // run/status register fields
    localparam int RS_TF_B = 7;
    localparam int RS_TR_B = 6;
    localparam int RS_TF_A = 5;
    localparam int RS_TR_A = 4;
    // mode register fields
    localparam int MD_GATE_B = 7;
    localparam int MD_CT_B = 6;
    localparam int MD_MODE_B = 4;
    localparam int MD_GATE_A = 3;
    localparam int MD_CT_A = 2;
    localparam int MD_MODE_A = 0;
    // clock, interrupt enable and gate config fields
    localparam int CK_SYS_B = 3;
    localparam int CK_SYS_A = 2;
    localparam int CK_DIV = 0;
    localparam int IE_EN_A = 1;
    localparam int IE_EN_B = 3;
    localparam int EC_POL_A = 3;
    localparam int EC_POL_B = 7;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // prescaler divide ratios
    localparam int PRESC_W = 6;
    localparam logic [5:0] DIV_12 = 6'h0C;
    localparam logic [5:0] DIV_4 = 6'h04;
    localparam logic [5:0] DIV_48 = 6'h30;
    localparam logic [5:0] DIV_EXT = 6'h08;
    // prescaler select codes
    localparam logic [1:0] SEL_12 = 2'h0;
    localparam logic [1:0] SEL_4 = 2'h1;
    localparam logic [1:0] SEL_48 = 2'h2;
    localparam logic [1:0] SEL_EXT = 2'h3;
    // synchronised pin lanes
    localparam int PIN_N = 5;
    localparam int PIN_CNT_A = 0;
    localparam int PIN_CNT_B = 1;
    localparam int PIN_IRQ_A = 2;
    localparam int PIN_IRQ_B = 3;
    localparam int PIN_EXT_CLK = 4;

    // timer operating modes
    typedef enum logic [1:0] {
        MODE_13 = 2'h0,
        MODE_16 = 2'h1,
        MODE_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } timer_mode_t;

    // one register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // result of one counting step
    typedef struct packed {
        logic ovf;
        logic [7:0] lo;
        logic [7:0] hi;
    } cnt_t;
endpackage : timer_pkg

/* rtl/dual_timer_counter_pair.sv */
// two counter/timers with mode select, shared prescaler, gating and split mode
// assumes a single-cycle strobe register port and asynchronous external pins
// Overview of operation
// (RULE1) each timer is sixteen bits, reached as a low and a high byte
// (RULE2) two mode bits per timer in the mode register pick one of four modes
// (RULE3) 13-bit mode: high byte top eight bits, low byte bits 4..0
// (RULE4) 13-bit wrap from all ones sets the overflow flag and requests an interrupt
// (RULE5) counter select set: count falling edges on the timer's count pin
// (RULE6) counter select clear: system clock or prescaler output, by clock-select bit
// (RULE7) prescaler divides clock by 12, 4, 48, or external clock by 8
// (RULE8) count only while run bit set and gate clear or gate input active
// (RULE9) timer b gates with second external input, polarity from config register
// (RULE10) setting the run bit leaves the count untouched
// (RULE11) software loads the starting count before setting the run bit
// (RULE12) overflow reaches interrupt output only when its enable bit is set
// (RULE13) timer b behaves like timer a with its own bytes and bits; in mode 3 timer b stops instead of splitting
// (RULE14) split mode: timer a becomes two 8-bit counters, low uses timer a bits
// (RULE15) split low counter may use system-derived clock or count pin
// (RULE16) split high counter: internal clock only, timer b run bit and flag
// (RULE17) while split, timer b ignores its pin and never sets its flag
// (RULE18) while split, timer b overflow still leaves as an event
// (RULE19) while split, timer b runs in modes 0 to 2, stops in mode 3
// (RULE20) mode 1 counts sixteen bits, flag on wrap from all ones
// (RULE21) mode 2 counts low byte, reloads it from high byte on overflow
// (RULE22) pins synchronised and edge detected before any counter
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_pair (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire timer_pkg::reg_req_t req_i,
    output logic [7:0] rdata_o,
    // external pins
    input wire logic count_a_pin_i,
    input wire logic count_b_pin_i,
    input wire logic ext_irq_a_input_i,
    input wire logic ext_irq_b_input_i,
    input wire logic ext_clk_i,
    // interrupt requests and timer b overflow event
    output logic irq_a_o,
    output logic irq_b_o,
    output logic timer_b_ovf_o
);
    typedef struct packed {
        logic [7:0] timer_a_low_byte;
        logic [7:0] timer_a_high_byte;
        logic [7:0] timer_b_low_byte;
        logic [7:0] timer_b_high_byte;
        logic [7:0] timer_run_status_reg;
        logic [7:0] timer_mode_reg;
        logic [7:0] timer_clock_control;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] ext_irq_config_reg;
        logic [7:0] rdata;
        logic b_ovf_evt;
    } core_t;
    core_t s;
    core_t next_s;

    logic [timer_pkg::PIN_N-1:0] pin_level;
    logic [timer_pkg::PIN_N-1:0] pin_fall;
    logic presc_tick;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic split;
    logic gate_a_ok;
    logic gate_b_ok;
    logic base_a;
    logic base_b;
    logic tick_a;
    logic tick_b;
    logic en_a;
    logic en_b;
    logic en_ah;
    logic count_a;
    logic count_b;
    logic count_ah;
    logic ovf_ah;
    logic set_flag_a;
    logic set_flag_b;
    logic wr_rs;
    timer_pkg::cnt_t cnt_a;
    timer_pkg::cnt_t cnt_b;

    // one counting step; split mode handled by caller
    function automatic timer_pkg::cnt_t step(input logic [1:0] md, input logic [7:0] lo, input logic [7:0] hi);
        timer_pkg::cnt_t r;
        logic [12:0] c13;
        logic [15:0] c16;
        r.ovf = 1'b0;
        r.lo = lo;
        r.hi = hi;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        case (md)
            timer_pkg::MODE_13: begin
                // low byte bits 7:5 kept, software masks them
                r.ovf = &{hi, lo[4:0]}; // see (RULE3) see (RULE4)
                r.hi = c13[12:5];
                r.lo = {lo[7:5], c13[4:0]};
            end
            timer_pkg::MODE_16: begin
                r.ovf = &{hi, lo}; // see (RULE20)
                r.hi = c16[15:8];
                r.lo = c16[7:0];
            end
            timer_pkg::MODE_RELOAD: begin
                r.ovf = &lo; // see (RULE21)
                r.lo = r.ovf ? hi : lo + 8'h01;
            end
            default: begin
                r.ovf = 1'b0;
            end
        endcase
        return r;
    endfunction : step

    // all pins through two flip-flops before use
    pin_sync #(
        .WIDTH(timer_pkg::PIN_N)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i({ext_clk_i, ext_irq_b_input_i, ext_irq_a_input_i, count_b_pin_i, count_a_pin_i}), // see (RULE22)
        .level_o(pin_level),
        .fall_o(pin_fall)
    );

    // shared prescaler
    timer_prescaler u_presc (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .sel_i(s.timer_clock_control[timer_pkg::CK_DIV +: 2]), // see (RULE7)
        .ext_fall_i(pin_fall[timer_pkg::PIN_EXT_CLK]),
        .tick_o(presc_tick)
    );

    // mode decode and gating
    always_comb begin
        mode_a = s.timer_mode_reg[timer_pkg::MD_MODE_A +: 2]; // see (RULE2)
        mode_b = s.timer_mode_reg[timer_pkg::MD_MODE_B +: 2]; // see (RULE2)
        split = (mode_a == timer_pkg::MODE_SPLIT); // see (RULE14)
        gate_a_ok = !s.timer_mode_reg[timer_pkg::MD_GATE_A]
            || (pin_level[timer_pkg::PIN_IRQ_A] == s.ext_irq_config_reg[timer_pkg::EC_POL_A]); // see (RULE8)
        gate_b_ok = !s.timer_mode_reg[timer_pkg::MD_GATE_B]
            || (pin_level[timer_pkg::PIN_IRQ_B] == s.ext_irq_config_reg[timer_pkg::EC_POL_B]); // see (RULE9)
        base_a = s.timer_clock_control[timer_pkg::CK_SYS_A] ? 1'b1 : presc_tick; // see (RULE6)
        base_b = s.timer_clock_control[timer_pkg::CK_SYS_B] ? 1'b1 : presc_tick; // see (RULE6) see (RULE13)
        // split low counter keeps timer a's clock choice
        tick_a = s.timer_mode_reg[timer_pkg::MD_CT_A] ? pin_fall[timer_pkg::PIN_CNT_A] : base_a; // see (RULE5) see (RULE15)
        // while split, timer b may not see its pin
        tick_b = (s.timer_mode_reg[timer_pkg::MD_CT_B] && !split) ? pin_fall[timer_pkg::PIN_CNT_B] : base_b; // see (RULE17)
        en_a = s.timer_run_status_reg[timer_pkg::RS_TR_A] && gate_a_ok; // see (RULE8) see (RULE14)
        if (split) begin
            // run control moves into the mode field
            en_b = (mode_b != timer_pkg::MODE_SPLIT); // see (RULE19)
        end else begin
            en_b = s.timer_run_status_reg[timer_pkg::RS_TR_B] && gate_b_ok
                && (mode_b != timer_pkg::MODE_SPLIT); // see (RULE13)
        end
        en_ah = s.timer_run_status_reg[timer_pkg::RS_TR_B]; // see (RULE16)
        count_a = en_a && tick_a;
        count_b = en_b && tick_b;
        count_ah = split && en_ah && base_a; // see (RULE16)
    end

    // counting, register writes and read data
    always_comb begin
        next_s = s;
        ovf_ah = 1'b0;
        cnt_a = '{ovf: 1'b0, lo: s.timer_a_low_byte, hi: s.timer_a_high_byte};
        if (split) begin
            if (count_a) begin
                cnt_a.ovf = &s.timer_a_low_byte; // see (RULE14)
                cnt_a.lo = s.timer_a_low_byte + 8'h01;
            end
            if (count_ah) begin
                ovf_ah = &s.timer_a_high_byte; // see (RULE16)
                cnt_a.hi = s.timer_a_high_byte + 8'h01;
            end
        end else if (count_a) begin
            cnt_a = step(mode_a, s.timer_a_low_byte, s.timer_a_high_byte);
        end
        cnt_b = '{ovf: 1'b0, lo: s.timer_b_low_byte, hi: s.timer_b_high_byte};
        if (count_b) begin
            cnt_b = step(mode_b, s.timer_b_low_byte, s.timer_b_high_byte); // see (RULE13)
        end
        set_flag_a = cnt_a.ovf;
        set_flag_b = split ? ovf_ah : cnt_b.ovf; // see (RULE17)
        next_s.b_ovf_evt = cnt_b.ovf; // see (RULE18)
        next_s.timer_a_low_byte = cnt_a.lo;
        next_s.timer_a_high_byte = cnt_a.hi;
        next_s.timer_b_low_byte = cnt_b.lo;
        next_s.timer_b_high_byte = cnt_b.hi;
        wr_rs = req_i.wr && (req_i.addr == timer_pkg::OFS_RUN_STATUS);
        // a byte write beats that cycle's increment
        if (req_i.wr) begin
            case (req_i.addr)
                timer_pkg::OFS_A_LOW: next_s.timer_a_low_byte = req_i.wdata; // see (RULE1)
                timer_pkg::OFS_A_HIGH: next_s.timer_a_high_byte = req_i.wdata; // see (RULE1)
                timer_pkg::OFS_B_LOW: next_s.timer_b_low_byte = req_i.wdata;
                timer_pkg::OFS_B_HIGH: next_s.timer_b_high_byte = req_i.wdata;
                // run bit only enables, count untouched
                timer_pkg::OFS_RUN_STATUS: next_s.timer_run_status_reg = req_i.wdata; // see (RULE10)
                timer_pkg::OFS_MODE: next_s.timer_mode_reg = req_i.wdata;
                timer_pkg::OFS_CLK_CTRL: next_s.timer_clock_control = req_i.wdata;
                timer_pkg::OFS_IRQ_EN: next_s.interrupt_enable_reg = req_i.wdata;
                timer_pkg::OFS_EXT_CFG: next_s.ext_irq_config_reg = req_i.wdata;
                default: begin
                end
            endcase
        end
        // hardware set beats a same-cycle software clear
        next_s.timer_run_status_reg[timer_pkg::RS_TF_A] = set_flag_a
            || (wr_rs ? req_i.wdata[timer_pkg::RS_TF_A] : s.timer_run_status_reg[timer_pkg::RS_TF_A]); // see (RULE4)
        next_s.timer_run_status_reg[timer_pkg::RS_TF_B] = set_flag_b
            || (wr_rs ? req_i.wdata[timer_pkg::RS_TF_B] : s.timer_run_status_reg[timer_pkg::RS_TF_B]); // see (RULE16)
        next_s.rdata = 8'h00;
        if (req_i.rd) begin
            case (req_i.addr)
                timer_pkg::OFS_A_LOW: next_s.rdata = s.timer_a_low_byte;
                timer_pkg::OFS_A_HIGH: next_s.rdata = s.timer_a_high_byte;
                timer_pkg::OFS_B_LOW: next_s.rdata = s.timer_b_low_byte;
                timer_pkg::OFS_B_HIGH: next_s.rdata = s.timer_b_high_byte;
                timer_pkg::OFS_RUN_STATUS: next_s.rdata = s.timer_run_status_reg;
                timer_pkg::OFS_MODE: next_s.rdata = s.timer_mode_reg;
                timer_pkg::OFS_CLK_CTRL: next_s.rdata = s.timer_clock_control;
                timer_pkg::OFS_IRQ_EN: next_s.rdata = s.interrupt_enable_reg;
                timer_pkg::OFS_EXT_CFG: next_s.rdata = s.ext_irq_config_reg;
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs; flags stay until software clears them
    assign rdata_o = s.rdata;
    assign irq_a_o = s.timer_run_status_reg[timer_pkg::RS_TF_A] && s.interrupt_enable_reg[timer_pkg::IE_EN_A]; // see (RULE12)
    assign irq_b_o = s.timer_run_status_reg[timer_pkg::RS_TF_B] && s.interrupt_enable_reg[timer_pkg::IE_EN_B]; // see (RULE12)
    assign timer_b_ovf_o = s.b_ovf_evt;

    // checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_read_a_low;
        req_i.rd && (req_i.addr == timer_pkg::OFS_A_LOW);
    endsequence
    property p_read_a_low;
        s_read_a_low |=> (rdata_o == $past(s.timer_a_low_byte)) ##1 (rdata_o == 8'h00 || $past(req_i.rd));
    endproperty
    a_read_a_low: assert property (p_read_a_low) else $error("read data wrong"); // see (RULE1)

    property p_wrap13;
        (!split && mode_a == timer_pkg::MODE_13 && count_a && (&{s.timer_a_high_byte, s.timer_a_low_byte[4:0]}) && !req_i.wr)
            |=> s.timer_run_status_reg[timer_pkg::RS_TF_A] && s.timer_a_high_byte == 8'h00;
    endproperty
    a_wrap13: assert property (p_wrap13) else $error("13-bit wrap"); // see (RULE4)

    property p_wrap16;
        (!split && mode_a == timer_pkg::MODE_16 && count_a && s.timer_a_low_byte == 8'hFF
            && s.timer_a_high_byte == 8'hFF && !req_i.wr)
            |=> s.timer_a_low_byte == 8'h00 && s.timer_a_high_byte == 8'h00 && s.timer_run_status_reg[timer_pkg::RS_TF_A];
    endproperty
    a_wrap16: assert property (p_wrap16) else $error("16-bit wrap"); // see (RULE20)

    property p_reload;
        (!split && mode_a == timer_pkg::MODE_RELOAD && count_a && s.timer_a_low_byte == 8'hFF && !req_i.wr)
            |=> s.timer_a_low_byte == $past(s.timer_a_high_byte);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload"); // see (RULE21)

    property p_hold_stopped;
        (!s.timer_run_status_reg[timer_pkg::RS_TR_A] && !req_i.wr) |=> $stable(s.timer_a_low_byte);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("stopped timer moved"); // see (RULE8)

    property p_gate_b;
        (!split && s.timer_mode_reg[timer_pkg::MD_GATE_B]
            && pin_level[timer_pkg::PIN_IRQ_B] != s.ext_irq_config_reg[timer_pkg::EC_POL_B] && !req_i.wr)
            |=> $stable(s.timer_b_low_byte) && $stable(s.timer_b_high_byte);
    endproperty
    a_gate_b: assert property (p_gate_b) else $error("gated timer b moved"); // see (RULE9)

    property p_pin_count;
        (!split && mode_a == timer_pkg::MODE_16 && en_a && s.timer_mode_reg[timer_pkg::MD_CT_A]
            && pin_fall[timer_pkg::PIN_CNT_A] && s.timer_a_low_byte != 8'hFF && !req_i.wr)
            |=> s.timer_a_low_byte == $past(s.timer_a_low_byte) + 8'h01;
    endproperty
    a_pin_count: assert property (p_pin_count) else $error("pin edge missed"); // see (RULE5)

    property p_irq_mask;
        (req_i.wr && req_i.addr == timer_pkg::OFS_IRQ_EN && !req_i.wdata[timer_pkg::IE_EN_A]) |=> !irq_a_o;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq"); // see (RULE12)

    property p_split_no_flag_b;
        (split && cnt_b.ovf && !ovf_ah && !s.timer_run_status_reg[timer_pkg::RS_TF_B] && !req_i.wr)
            |=> !s.timer_run_status_reg[timer_pkg::RS_TF_B] && timer_b_ovf_o;
    endproperty
    a_split_no_flag_b: assert property (p_split_no_flag_b) else $error("split flag b"); // see (RULE17) see (RULE18)

    property p_split_stop_b;
        (split && mode_b == timer_pkg::MODE_SPLIT && !req_i.wr) |=> $stable(s.timer_b_low_byte);
    endproperty
    a_split_stop_b: assert property (p_split_stop_b) else $error("timer b ran in mode 3"); // see (RULE19)

    property p_split_high;
        (split && en_ah && base_a && s.timer_a_high_byte == 8'hFF) |=> s.timer_run_status_reg[timer_pkg::RS_TF_B];
    endproperty
    a_split_high: assert property (p_split_high) else $error("split high ovf"); // see (RULE16)

    sequence s_div4_run;
        (presc_tick && s.timer_clock_control[1:0] == timer_pkg::SEL_4 && !(req_i.wr && req_i.addr == timer_pkg::OFS_CLK_CTRL))
            ##1 (s.timer_clock_control[1:0] == timer_pkg::SEL_4) [*3];
    endsequence
    property p_div4;
        s_div4_run |-> ##1 presc_tick;
    endproperty
    a_div4: assert property (p_div4) else $error("divide by 4"); // see (RULE7)
endmodule : dual_timer_counter_pair
`default_nettype wire

/* rtl/pin_sync.sv */
// two-stage synchronisers with falling edge detect, one lane per pin
// assumes pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // raw pins
    input wire logic [WIDTH-1:0] pin_i,
    // synchronised level and falling edge pulse
    output logic [WIDTH-1:0] level_o,
    output logic [WIDTH-1:0] fall_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
        logic [WIDTH-1:0] prev;
    } sync_t;
    sync_t s;
    sync_t next_s;

    // meta stage is read only by the sync stage
    always_comb begin
        next_s.meta = pin_i;
        next_s.sync = s.meta;
        next_s.prev = s.sync;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // edges come from the settled stages only
    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        assign level_o[i] = s.sync[i];
        assign fall_o[i] = s.prev[i] & ~s.sync[i];
    end
endmodule : pin_sync
`default_nettype wire

/* rtl/timer_prescaler.sv */
// shared prescaler: one-cycle tick per 12, 4 or 48 clocks or 8 external falls
// assumes ext_fall_i is already synchronised
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic [1:0] sel_i,
    input wire logic ext_fall_i,
    // output
    output logic tick_o
);
    typedef struct packed {
        logic [timer_pkg::PRESC_W-1:0] cnt;
        logic tick;
    } presc_t;
    presc_t s;
    presc_t next_s;
    logic [timer_pkg::PRESC_W-1:0] limit;
    logic step;

    // ratio decode; a count beyond a new, smaller ratio wraps on its next step
    always_comb begin
        case (sel_i)
            timer_pkg::SEL_12: limit = timer_pkg::DIV_12;
            timer_pkg::SEL_4: limit = timer_pkg::DIV_4;
            timer_pkg::SEL_48: limit = timer_pkg::DIV_48;
            default: limit = timer_pkg::DIV_EXT;
        endcase
        step = (sel_i == timer_pkg::SEL_EXT) ? ext_fall_i : 1'b1;
        next_s = s;
        next_s.tick = 1'b0;
        if (step) begin
            if (s.cnt >= limit - 6'h01) begin
                next_s.cnt = '0;
                next_s.tick = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;
endmodule : timer_prescaler

/* testbench/pin_model.sv */
// far-side model of the count, gate and external clock pins
// assumes pins stand still between task calls
`timescale 1ns/1ps
`default_nettype none
module pin_model (
    // clock
    input wire logic sys_clk_i,
    // pin lanes, in the package's lane order
    output logic [4:0] pins_o
);
    // count and clock pins idle high, gate pins low
    initial pins_o = 5'h13;
    // low held 3 cycles, high 4 between falls, above the 2-cycle minimum
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge sys_clk_i) pins_o[idx] <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            pins_o[idx] <= 1'b1;
            repeat (3) @(posedge sys_clk_i);
        end
    endtask : pulse
    // gate input level
    task automatic set_level(input int idx, input logic v);
        @(posedge sys_clk_i) pins_o[idx] <= v;
    endtask : set_level
endmodule : pin_model
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the dual counter/timer pair
// assumes pin_model and the strobe register port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    timer_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic [4:0] pins;
    logic irq_a, irq_b, b_ovf;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00007C32;
    logic [7:0] d, e, r;
    int n;
    dual_timer_counter_pair i_dual_timer_counter_pair (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .rdata_o(rdata), .count_a_pin_i(pins[timer_pkg::PIN_CNT_A]), .count_b_pin_i(pins[timer_pkg::PIN_CNT_B]),
        .ext_irq_a_input_i(pins[timer_pkg::PIN_IRQ_A]), .ext_irq_b_input_i(pins[timer_pkg::PIN_IRQ_B]),
        .ext_clk_i(pins[timer_pkg::PIN_EXT_CLK]), .irq_a_o(irq_a), .irq_b_o(irq_b), .timer_b_ovf_o(b_ovf));
    pin_model i_pin_model (.sys_clk_i(sys_clk_i), .pins_o(pins));
    // 125 MHz
    initial forever #4 sys_clk_i = ~sys_clk_i;
    // hang guard, tests take a few thousand cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    // count after w cycles at ratio div, phase unknown
    function automatic logic in_window(input logic [7:0] got, input int w, input int div);
        return (int'(got) >= w / div - 1) && (int'(got) <= w / div + 1);
    endfunction : in_window
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk_i) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i) req.wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk_i) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_i) req.rd <= 1'b0;
        #1 v = rdata;
    endtask : rd
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8
    task automatic chk1(input string nm, input logic exp, input logic got);
        chk8(nm, {7'h00, exp}, {7'h00, got});
    endtask : chk1
    // bounded wait for an output to rise; looks 1 ns after each edge, so one-cycle pulses are caught
    task automatic wait_high(input int which, input int lim);
        #1;
        for (int i = 0; i < lim && !((which == 0) ? irq_a === 1'b1 : (which == 1) ? irq_b === 1'b1 : b_ovf === 1'b1); i++)
            @(posedge sys_clk_i) #1;
    endtask : wait_high
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        // reset values, unmapped offset 9 reads zero
        for (int a = 0; a < 10; a++) begin
            rd(4'(a), d);
            chk8("reset value", 8'h00, d);
        end
        $display("test reset done");
        // random bytes through all count bytes
        for (int a = 0; a < 4; a++) begin
            seed = xorshift(seed);
            wr(4'(a), seed[7:0]);
            rd(4'(a), d);
            chk8("byte readback", seed[7:0], d);
        end
        $display("test bytes done");
        // 16-bit wrap from sys clock, load before run
        wr(timer_pkg::OFS_A_LOW, 8'hF0);
        wr(timer_pkg::OFS_A_HIGH, 8'hFF);
        wr(timer_pkg::OFS_MODE, 8'h01);
        wr(timer_pkg::OFS_CLK_CTRL, 8'h04);
        wr(timer_pkg::OFS_IRQ_EN, 8'h02);
        wr(timer_pkg::OFS_RUN_STATUS, 8'h10);
        wait_high(0, 40);
        chk1("irq a on wrap", 1'b1, irq_a);
        wr(timer_pkg::OFS_IRQ_EN, 8'h00);
        #1 chk1("irq a masked", 1'b0, irq_a);
        rd(timer_pkg::OFS_RUN_STATUS, d);
        chk1("flag a", 1'b1, d[timer_pkg::RS_TF_A]);
        $display("test wrap done");
        // inactive gate input holds the count
        wr(timer_pkg::OFS_RUN_STATUS, 8'h00);
        wr(timer_pkg::OFS_A_LOW, 8'h00);
        wr(timer_pkg::OFS_EXT_CFG, 8'h08);
        wr(timer_pkg::OFS_MODE, 8'h09);
        wr(timer_pkg::OFS_RUN_STATUS, 8'h10);
        repeat (50) @(posedge sys_clk_i);
        rd(timer_pkg::OFS_A_LOW, d);
        chk8("gated hold", 8'h00, d);
        i_pin_model.set_level(timer_pkg::PIN_IRQ_A, 1'b1);
        repeat (20) @(posedge sys_clk_i);
        rd(timer_pkg::OFS_A_LOW, d);
        chk1("gate open counts", 1'b1, d > 8'h0A);
        $display("test gate done");
        // count pin falls, random start and number
        seed = xorshift(seed);
        r = {2'h0, seed[5:0]};
        n = 1 + int'(seed[12:8]);
        wr(timer_pkg::OFS_RUN_STATUS, 8'h00);
        wr(timer_pkg::OFS_A_LOW, r);
        wr(timer_pkg::OFS_MODE, 8'h05);
        wr(timer_pkg::OFS_RUN_STATUS, 8'h10);
        i_pin_model.pulse(timer_pkg::PIN_CNT_A, n);
        repeat (6) @(posedge sys_clk_i);
        rd(timer_pkg::OFS_A_LOW, d);
        chk8("pin count", r + 8'(n), d);
        $display("test pin count done");
        // every prescaler code; code 3 counts external falls
        for (int s = 0; s < 4; s++) begin
            wr(timer_pkg::OFS_RUN_STATUS, 8'h00);
            wr(timer_pkg::OFS_A_LOW, 8'h00);
            wr(timer_pkg::OFS_MODE, 8'h01);
            wr(timer_pkg::OFS_CLK_CTRL, 8'(s));
            wr(timer_pkg::OFS_RUN_STATUS, 8'h10);
            if (s == 3)
                i_pin_model.pulse(timer_pkg::PIN_EXT_CLK, 80);
            else
                repeat (478) @(posedge sys_clk_i);
            wr(timer_pkg::OFS_RUN_STATUS, 8'h00);
            rd(timer_pkg::OFS_A_LOW, d);
            n = (s == 0) ? 12 : (s == 1) ? 4 : (s == 2) ? 48 : 8;
            chk1("prescaled count", 1'b1, in_window(d, (s == 3) ? 80 : 480, n));
        end
        $display("test prescaler done");
        // split: timer a high byte sets flag b; timer b wraps on its first tick
        wr(timer_pkg::OFS_CLK_CTRL, 8'h04);
        wr(timer_pkg::OFS_A_HIGH, 8'hF8);
        wr(timer_pkg::OFS_B_LOW, 8'h1F);
        wr(timer_pkg::OFS_B_HIGH, 8'hFF);
        wr(timer_pkg::OFS_IRQ_EN, 8'h08);
        wr(timer_pkg::OFS_MODE, 8'h03);
        wr(timer_pkg::OFS_RUN_STATUS, 8'h40);
        wait_high(2, 40);
        chk1("timer b event while split", 1'b1, b_ovf);
        wait_high(1, 40);
        chk1("irq b from split high byte", 1'b1, irq_b);
        wr(timer_pkg::OFS_MODE, 8'h33);
        rd(timer_pkg::OFS_B_LOW, d);
        i_pin_model.pulse(timer_pkg::PIN_CNT_B, 3);
        rd(timer_pkg::OFS_B_LOW, e);
        chk8("timer b stopped in mode 3", d, e);
        $display("test split done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
